// File: rtl/rps_pkg.sv
// Purpose: Constants for the reset and clock-ratio sequencer
// Assumes: i_clk is the oscillator clock at 25 MHz; all counts in its cycles
// Notes: Contract
package rps_pkg;
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned RST_MIN_CYC = 8;
   localparam int unsigned SUPPLY_HOLD_US = 1000;
   localparam int unsigned SUPPLY_HOLD_CYC = (SUPPLY_HOLD_US * (CLK_HZ / 1000000));
   localparam int unsigned WD_PULSE_CYC = 512;
   localparam int unsigned BUS_VALID_CYC = 32;
   localparam int unsigned BOOT_HOLD_CYC = 200;
   localparam int unsigned LOCK_CYC = 131072;
   localparam logic [15:0] RATIO_X2 = 16'h0004;
   localparam logic [15:0] RATIO_X4 = 16'h0008;
   localparam logic [15:0] RATIO_RESET = 16'h0000;
   // Output ratio encoding: 0 = half, 1 = one, 2 = two, 4 = four times
   localparam logic [2:0] MUL_HALF = 3'h0;
   localparam logic [2:0] MUL_ONE = 3'h1;
   localparam logic [2:0] MUL_TWO = 3'h2;
   localparam logic [2:0] MUL_FOUR = 3'h4;
   typedef enum logic [1:0] {RPS_RESET, RPS_WAIT_BUS, RPS_RUN} rps_state_type;
endpackage

// File: rtl/rps_reset_and_pll_sequencer.sv
// Purpose: Qualify external reset, stretch watchdog reset, sequence ratio lock-up
// Assumes: i_clk is the selected oscillator clock; clock select mux is outside
// Notes: The system clock itself is produced elsewhere from o_clk_mult
// Notes: A reset pin held low for the minimum time always resets the core;
//        shorter low pulses are treated as noise and leave the core running
`timescale 1ns/1ps
`default_nettype none
module rps_reset_and_pll_sequencer
   import rps_pkg::*;
#(
   parameter int unsigned LOCK_CYCLES = LOCK_CYC,
   parameter int unsigned SUPPLY_CYCLES = SUPPLY_HOLD_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_external_reset_n,
   input wire logic i_osc_select_ext,
   input wire logic i_watchdog_trip,
   input wire logic i_ratio_write,
   input wire logic [15:0] i_ratio_data,
   output logic o_osc_select_ext,
   output logic o_core_reset_n,
   output logic o_watchdog_reset_n,
   output logic o_bus_valid,
   output logic o_boot_sample,
   output logic o_locking,
   output logic [2:0] o_clk_mult
);
   localparam int unsigned CW = $clog2(LOCK_CYCLES + 1);
   // Elaboration checks: the counters below are sized for these figures
   if (LOCK_CYCLES < 1) begin : g_lock_check
      $error("rps: lock count must be at least one cycle");
   end
   if (SUPPLY_CYCLES < RST_MIN_CYC) begin : g_supply_check
      $error("rps: supply hold shorter than the minimum reset");
   end
   if (WD_PULSE_CYC > 1024 || BOOT_HOLD_CYC > 256 || RST_MIN_CYC > 16) begin : g_width_check
      $error("rps: watchdog, release or qualifier counter too narrow");
   end
   if (BUS_VALID_CYC < 2 || BUS_VALID_CYC >= BOOT_HOLD_CYC) begin : g_order_check
      $error("rps: bus valid must come after release and before boot sampling");
   end

   // Ratio code to multiplier; codes other than the two known targets run at x1,
   // so an unlisted code never selects an untried rate
   function automatic logic [2:0] ratio_mul(input logic [15:0] r);
      case (r)
         RATIO_X2: ratio_mul = MUL_TWO;
         RATIO_X4: ratio_mul = MUL_FOUR;
         default: ratio_mul = MUL_ONE;
      endcase
   endfunction

   // Synchroniser stages for the two asynchronous pins
   logic rst_s1;
   logic rst_s2;
   logic sel_s1;
   logic sel_s2;
   // Low-time qualifier of the reset pin
   logic [3:0] low_cnt;
   logic qual_low;
   // Watchdog pulse stretcher
   logic [9:0] wd_cnt;
   logic wd_active;
   // Release sequencer
   logic [7:0] rel_cnt;
   rps_state_type state;
   // Lock-up timer and the ratio it is heading for
   logic [CW-1:0] lock_cnt;
   logic [15:0] ratio;

   // Release timeline in oscillator cycles, pin first sampled high at edge P:
   //    P+1   second synchroniser stage sees the pin high
   //    P+2   qualified-low flag clears
   //    P+3   core reset released, release counter loaded with one
   //    +31   bus outputs flagged valid, level held until the next reset
   //    +199  boot pins sampled, one-cycle strobe
   // A watchdog pulse holds the same sequence in reset while it runs, so a
   // watchdog reset replays bus-valid and boot sampling like a pin reset.
   // Ratio writes are ignored while the core is in reset; no software runs
   // before release anyway.

   // Two-stage synchroniser of the reset pin and the clock select pin
   // Only the second stage reads a first stage, keeping metastability contained
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
         sel_s1 <= 1'b0;
         sel_s2 <= 1'b0;
      end else begin
         rst_s1 <= i_external_reset_n;
         rst_s2 <= rst_s1;
         sel_s1 <= i_osc_select_ext;
         sel_s2 <= sel_s1;
      end
   end

   // Oscillator source selection reported to the clock mux
   // Registered once more so the select output comes straight from a flop
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_osc_select_ext <= 1'b0;
      end else begin
         o_osc_select_ext <= sel_s2;
      end
   end

   // Low pulses shorter than the minimum are ignored as glitches. The flag sets on
   // the sample that completes the minimum hold, so a driver keeping exactly to the
   // minimum still resets the core; one cycle less is filtered out.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         low_cnt <= '0;
         qual_low <= 1'b1;
      end else if (!rst_s2) begin
         if (low_cnt < 4'(RST_MIN_CYC - 1)) begin
            low_cnt <= low_cnt + 4'h1;
         end else begin
            qual_low <= 1'b1;
         end
      end else begin
         low_cnt <= '0;
         qual_low <= 1'b0;
      end
   end

   // Watchdog trip stretches into a fixed-length reset pulse
   // A trip while the pulse runs is ignored; the pulse is never stretched further
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wd_cnt <= '0;
         wd_active <= 1'b0;
         o_watchdog_reset_n <= 1'b1;
      end else if (i_watchdog_trip && !wd_active) begin
         wd_cnt <= 10'(WD_PULSE_CYC - 1);
         wd_active <= 1'b1;
         o_watchdog_reset_n <= 1'b0;
      end else if (wd_active) begin
         if (wd_cnt == 10'h000) begin
            wd_active <= 1'b0;
            o_watchdog_reset_n <= 1'b1;
         end else begin
            wd_cnt <= wd_cnt - 10'h001;
         end
      end
   end

   // Release sequence: bus valid after 32 cycles, boot sampled at 200
   // Any qualified pin reset or running watchdog pulse restarts the sequence
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= RPS_RESET;
         rel_cnt <= '0;
         o_core_reset_n <= 1'b0;
         o_bus_valid <= 1'b0;
         o_boot_sample <= 1'b0;
      end else if (qual_low || wd_active) begin
         state <= RPS_RESET;
         rel_cnt <= '0;
         o_core_reset_n <= 1'b0;
         o_bus_valid <= 1'b0;
         o_boot_sample <= 1'b0;
      end else begin
         o_boot_sample <= 1'b0;
         case (state)
            RPS_RESET: begin
               state <= RPS_WAIT_BUS;
               o_core_reset_n <= 1'b1;
               rel_cnt <= 8'h01;
            end
            RPS_WAIT_BUS: begin
               rel_cnt <= rel_cnt + 8'h01;
               if (rel_cnt == 8'(BUS_VALID_CYC - 1)) begin
                  o_bus_valid <= 1'b1;
               end
               if (rel_cnt == 8'(BOOT_HOLD_CYC - 1)) begin
                  o_boot_sample <= 1'b1;
                  state <= RPS_RUN;
               end
            end
            RPS_RUN: begin
               // Parked until the next qualified reset or watchdog pulse
               state <= RPS_RUN;
            end
            default: begin
               state <= RPS_RESET;
            end
         endcase
      end
   end

   // Ratio write starts lock-up; system clock halves until the count ends
   // A write during lock-up restarts the count with the new ratio, so the clock
   // stays at half rate for a full lock period from the last write
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ratio <= RATIO_RESET;
         lock_cnt <= '0;
         o_locking <= 1'b0;
         o_clk_mult <= MUL_ONE;
      end else if (!o_core_reset_n) begin
         ratio <= RATIO_RESET;
         lock_cnt <= '0;
         o_locking <= 1'b0;
         o_clk_mult <= MUL_ONE;
      end else if (i_ratio_write) begin
         ratio <= i_ratio_data;
         lock_cnt <= CW'(LOCK_CYCLES - 1);
         o_locking <= 1'b1;
         o_clk_mult <= MUL_HALF;
      end else if (o_locking) begin
         if (lock_cnt == '0) begin
            o_locking <= 1'b0;
            o_clk_mult <= ratio_mul(ratio);
         end else begin
            lock_cnt <= lock_cnt - CW'(1);
         end
      end
   end
endmodule
`default_nettype wire

// File: tb/rps_checker_sva.sv
// Purpose: Port checker for the reset and ratio sequencer
// Assumes: one clock, async active-low reset
// Notes: Bound to the top module below
`timescale 1ns/1ps
`default_nettype none
module rps_checker
   import rps_pkg::*;
#(parameter int LOCK_CYCLES = 64) (
   input wire logic i_clk, i_rst_n, i_external_reset_n, i_osc_select_ext,
   input wire logic i_watchdog_trip, i_ratio_write,
   input wire logic [15:0] i_ratio_data,
   input wire logic o_osc_select_ext, o_core_reset_n, o_watchdog_reset_n,
   input wire logic o_bus_valid, o_boot_sample, o_locking,
   input wire logic [2:0] o_clk_mult
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   logic [15:0] rd;
   // Last written ratio, to predict the multiplier once lock ends
   always_ff @(posedge i_clk) if (i_ratio_write) rd <= i_ratio_data;
   logic [31:0] lock_run;
   // Cycles of the current lock-up, restarted by every accepted ratio write
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lock_run <= '0;
      end else if (i_ratio_write && o_core_reset_n) begin
         lock_run <= '0;
      end else if (o_locking) begin
         lock_run <= lock_run + 32'h1;
      end
   end
   chk_wd_start: assert property (i_watchdog_trip && o_watchdog_reset_n |=> !o_watchdog_reset_n)
      else $error("wd start");
   chk_wd_len: assert property ($fell(o_watchdog_reset_n) |-> ##[511:511] !o_watchdog_reset_n ##1 o_watchdog_reset_n)
      else $error("wd len");
   chk_bus_delay: assert property ($rose(o_core_reset_n) |-> ##30 !o_bus_valid ##1 o_bus_valid)
      else $error("bus delay");
   chk_boot_pulse: assert property ($rose(o_core_reset_n) |-> ##199 o_boot_sample ##1 !o_boot_sample)
      else $error("boot pulse");
   chk_core_sync: assert property ($rose(o_core_reset_n) |-> $past(i_external_reset_n, 3))
      else $error("core sync");
   chk_lock_go: assert property (i_ratio_write && o_core_reset_n |=> o_locking)
      else $error("lock go");
   chk_lock_half: assert property (o_locking |-> o_clk_mult == MUL_HALF)
      else $error("lock half");
   chk_lock_len: assert property ($fell(o_locking) |-> lock_run == 32'(LOCK_CYCLES))
      else $error("lock len");
   chk_mult_new: assert property ($fell(o_locking) |-> o_clk_mult == (rd == RATIO_X2 ? MUL_TWO : rd == RATIO_X4 ? MUL_FOUR : MUL_ONE))
      else $error("mult");
   cover property ($fell(o_locking));
   cover property ($rose(o_watchdog_reset_n));
   cover property (o_boot_sample);
endmodule
bind rps_reset_and_pll_sequencer rps_checker #(.LOCK_CYCLES(LOCK_CYCLES)) rps_checker_inst (
   .i_clk, .i_rst_n, .i_external_reset_n, .i_osc_select_ext, .i_watchdog_trip, .i_ratio_write,
   .i_ratio_data, .o_osc_select_ext, .o_core_reset_n, .o_watchdog_reset_n, .o_bus_valid,
   .o_boot_sample, .o_locking, .o_clk_mult);
`default_nettype wire

// File: tb/rps_supervisor.sv
// Purpose: External reset supervisor model
// Assumes: hold counted in oscillator clocks
// Notes: A short hold is a fault the bench commands
`timescale 1ns/1ps
`default_nettype none
module rps_supervisor
   import rps_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = SUPPLY_HOLD_CYC
) (
   input wire logic i_clk,
   input wire logic i_go,
   input wire logic [7:0] i_len,
   output logic o_reset_n
);
   logic [7:0] cnt = 8'h00;
   // Pin stays low for the commanded count of cycles
   always @(posedge i_clk) cnt <= i_go ? i_len : cnt - 8'(cnt != 8'h00);
   int unsigned pwr = HOLD_CYCLES;
   // Power-up hold counts from the first edge; the clock is stable from the start
   always @(posedge i_clk) if (pwr != 0) pwr <= pwr - 1;
   assign o_reset_n = (cnt == 8'h00) && (pwr == 0);
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Purpose: Self-checking bench for the reset and ratio sequencer
// Assumes: lock shortened to 64 cycles; supervisor keeps the full supply hold
// Notes: Results are matched in order against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import rps_pkg::*;
   logic i_clk = 0, i_rst_n = 0, i_osc_select_ext = 0, i_watchdog_trip = 0, i_ratio_write = 0;
   logic [15:0] i_ratio_data = 16'h0000;
   wire i_external_reset_n;
   logic o_osc_select_ext, o_core_reset_n, o_watchdog_reset_n, o_bus_valid, o_boot_sample;
   logic o_locking, go = 0, pb = 0, pl = 0, ps = 0;
   logic [2:0] o_clk_mult;
   logic [7:0] len = 8'h00;
   logic [15:0] q[$], d;
   int fails = 0, check_count = 0, seed = 40703, c = 0, w = 0, cyc = 0;
   localparam int LIMIT = SUPPLY_HOLD_CYC + 3000;
   // Oscillator clock, 40 ns period
   initial forever #20 i_clk = ~i_clk;
   rps_reset_and_pll_sequencer #(.LOCK_CYCLES(64)) rps_reset_and_pll_sequencer_inst (.i_clk,
      .i_rst_n, .i_external_reset_n, .i_osc_select_ext, .i_watchdog_trip, .i_ratio_write,
      .i_ratio_data, .o_osc_select_ext, .o_core_reset_n, .o_watchdog_reset_n, .o_bus_valid,
      .o_boot_sample, .o_locking, .o_clk_mult);
   rps_supervisor rps_supervisor_inst (.i_clk, .i_go(go), .i_len(len), .o_reset_n(i_external_reset_n));
   task automatic chk(input logic [15:0] g);
      logic [15:0] e;
      e = q.size() ? q.pop_front() : 16'hxxxx;
      check_count++;
      if (g !== e) begin
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
         fails++;
      end
   endtask
   task automatic summarize;
      if (q.size() != 0) begin
         $display("mismatch t=%0t got=%h exp=%h", $time, 16'hxxxx, q[0]);
         fails++;
      end
      $display("fails=%0d checks=%0d", fails, check_count);
      if (fails == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Watch outputs on the falling edge, once settled; counts run from core release
   always @(negedge i_clk) begin
      cyc++;
      if (i_rst_n) begin
         c = o_core_reset_n ? c + 1 : 0;
         if (o_bus_valid && !pb) chk(16'(c));
         if (o_boot_sample) chk(16'(c));
         if (o_watchdog_reset_n && w != 0) chk(16'(w));
         w = o_watchdog_reset_n ? 0 : w + 1;
         if (pl && !o_locking) chk({13'h0000, o_clk_mult});
         if (o_osc_select_ext != ps) chk({15'h0000, o_osc_select_ext});
      end
      pb = o_bus_valid;
      pl = o_locking;
      ps = o_osc_select_ext;
   end
   // Ceiling: supply hold plus about 1700 cycles of scenarios, with margin
   initial begin
      wait (cyc == LIMIT);
      fails++;
      summarize();
   end
   // Stimulus: reset, ratio codes, source select, watchdog, glitch and warm reset
   initial begin
      repeat (4) @(posedge i_clk);
      i_rst_n <= 1'b1;
      q = {16'h0020, 16'h00c8};
      repeat (SUPPLY_HOLD_CYC + 260) @(posedge i_clk);
      for (int i = 0; i < 4; i++) begin
         d = (i == 0) ? RATIO_X2 : (i == 1) ? RATIO_X4 : 16'($random(seed));
         q.push_back(d == RATIO_X2 ? 16'h0002 : d == RATIO_X4 ? 16'h0004 : 16'h0001);
         i_ratio_write <= 1'b1;
         i_ratio_data <= d;
         @(posedge i_clk) i_ratio_write <= 1'b0;
         repeat (70) @(posedge i_clk);
      end
      i_osc_select_ext <= 1'b1;
      q.push_back(16'h0001);
      repeat (10) @(posedge i_clk);
      i_watchdog_trip <= 1'b1;
      q = {q, 16'h0200, 16'h0020, 16'h00c8};
      @(posedge i_clk) i_watchdog_trip <= 1'b0;
      repeat (800) @(posedge i_clk);
      len <= 8'(RST_MIN_CYC - 1);
      go <= 1'b1;
      @(posedge i_clk) go <= 1'b0;
      repeat (60) @(posedge i_clk);
      len <= 8'(RST_MIN_CYC);
      go <= 1'b1;
      q = {q, 16'h0020, 16'h00c8};
      @(posedge i_clk) go <= 1'b0;
      repeat (300) @(posedge i_clk);
      summarize();
   end
endmodule
`default_nettype wire
